// file: rtl/dtc_pkg.sv
package dtc_pkg;

  // register offsets (8-bit port, byte addresses)
  localparam logic [7:0] OFS_BYTE_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SHARED_CTRL = 8'h01;
  localparam logic [7:0] OFS_WORD_CTRL   = 8'h02;
  localparam logic [7:0] OFS_BYTE_LOW    = 8'h04;
  localparam logic [7:0] OFS_BYTE_HIGH   = 8'h05;
  localparam logic [7:0] OFS_WORD_LOW    = 8'h06;
  localparam logic [7:0] OFS_WORD_HIGH   = 8'h07;

  // per-timer control register layout
  typedef struct packed {
    logic       enable;    // d7
    logic       one_shot;  // d6: 1 one-shot, 0 repeating
    logic       timeout;   // d5: write 1 to clear
    logic [2:0] spare;     // d4..d2
    logic       irq_en;    // d1
    logic       pin_en;    // d0
  } dtc_tctl_t;

  // shared control register layout
  typedef struct packed {
    logic       demod;     // d7: 1 demodulation, 0 transmit
    logic       comb_pin;  // d6
    logic [1:0] logic_sel; // d5..d4: combine function / edge select
    logic [1:0] submode;   // d3..d2: submode / glitch width
    logic       init_byte; // d1: byte initial level / rising flag
    logic       init_word; // d0: word initial level / falling flag
  } dtc_sctl_t;

  localparam dtc_tctl_t TCTL_RESET = 8'h00;
  localparam dtc_sctl_t SCTL_RESET = 8'h00;

  // bit positions of write-1-to-clear fields
  localparam int TIMEOUT_BIT = 5;
  localparam int RISE_BIT    = 1;
  localparam int FALL_BIT    = 0;

  // submode codes in transmit
  localparam logic [1:0] SUB_NORMAL = 2'h0;
  localparam logic [1:0] SUB_ALT    = 2'h1;
  localparam logic [1:0] SUB_LOW    = 2'h2;
  localparam logic [1:0] SUB_HIGH   = 2'h3;

  // combine functions
  localparam logic [1:0] COMB_AND  = 2'h0;
  localparam logic [1:0] COMB_OR   = 2'h1;
  localparam logic [1:0] COMB_NOR  = 2'h2;
  localparam logic [1:0] COMB_NAND = 2'h3;

  // timer clock divider: one tick every TICK_DIV system clocks
  localparam logic [3:0] TICK_DIV = 4'h4;

  // glitch widths in system clocks for submode 0..3
  localparam logic [4:0] GLITCH_W0 = 5'h01;
  localparam logic [4:0] GLITCH_W1 = 5'h04;
  localparam logic [4:0] GLITCH_W2 = 5'h08;
  localparam logic [4:0] GLITCH_W3 = 5'h10;

  // counter terminal value before reaching zero
  localparam logic [7:0]  BYTE_LAST = 8'h01;
  localparam logic [15:0] WORD_LAST = 16'h0001;

endpackage

// file: rtl/dtc_timer.sv
//
// Behaviour
// - transmit: logic select merges byte and word outputs by and/or/nor/nand
// - demodulation: same field selects which edge polarity is detected
// - submode selects alternating or normal; normal ends alternation at once
// - submode 10 forces word output low, 11 forces it high
// - demodulation: submode sets glitch width the filter removes
// - byte output takes its initial-level bit when counting starts
// - disabled byte output rests at inverse of its initial-level bit
// - demodulation: rising edge sets rising flag; writing 1 clears
// - demodulation: falling edge sets falling flag; writing 1 clears
// - word output starts at its initial level, rests inverted when off
// - word initial level applies only in normal or alternating submode
// - byte timer loads low hold if initial level 0, else high hold
// - one-shot: count to zero, stop, toggle, set timeout, interrupt
// - repeating: toggle, byte reloads by level, word from its hold; timeout each full cycle
// - hold register writes take effect only at next reload
// - re-enabling a timer reloads the programmed initial count
// - alternating: at a one-shot terminal hardware swaps enables and sets timeout
// - pin enable bits route byte and word outputs to pins
// - combine pin bit routes combined output to the third pin
//
`timescale 1ns/10ps
`default_nettype none

module dtc_timer (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // demodulation input
  input  wire logic       demod_in,
  // pins
  output logic            first_pin_out,
  output logic            first_pin_oe,
  output logic            second_pin_out,
  output logic            second_pin_oe,
  output logic            third_pin_out,
  output logic            third_pin_oe,
  // interrupt requests
  output logic            byte_irq,
  output logic            word_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  dtc_pkg::dtc_tctl_t byte_ctrl_reg;
  dtc_pkg::dtc_tctl_t byte_ctrl_next;
  dtc_pkg::dtc_tctl_t word_ctrl_reg;
  dtc_pkg::dtc_tctl_t word_ctrl_next;
  dtc_pkg::dtc_sctl_t shared_reg;
  dtc_pkg::dtc_sctl_t shared_next;

  logic [7:0]  byte_low_reg;
  logic [7:0]  byte_high_reg;
  logic [7:0]  word_low_reg;
  logic [7:0]  word_high_reg;
  logic [7:0]  byte_cnt_reg;
  logic [7:0]  byte_cnt_next;
  logic [15:0] word_cnt_reg;
  logic [15:0] word_cnt_next;
  logic        byte_out_reg;
  logic        byte_out_next;
  logic        word_out_reg;
  logic        word_out_next;
  logic        byte_en_prev_reg;
  logic        word_en_prev_reg;
  logic [3:0]  tick_cnt_reg;
  logic        tick_reg;
  logic        filt_reg;
  logic        filt_prev_reg;
  logic [4:0]  filt_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire wr_byte_ctrl = reg_wr && (reg_addr == dtc_pkg::OFS_BYTE_CTRL);
  wire wr_shared    = reg_wr && (reg_addr == dtc_pkg::OFS_SHARED_CTRL);
  wire wr_word_ctrl = reg_wr && (reg_addr == dtc_pkg::OFS_WORD_CTRL);
  wire wr_byte_low  = reg_wr && (reg_addr == dtc_pkg::OFS_BYTE_LOW);
  wire wr_byte_high = reg_wr && (reg_addr == dtc_pkg::OFS_BYTE_HIGH);
  wire wr_word_low  = reg_wr && (reg_addr == dtc_pkg::OFS_WORD_LOW);
  wire wr_word_high = reg_wr && (reg_addr == dtc_pkg::OFS_WORD_HIGH);

  wire [7:0] rd_mux =
    (reg_addr == dtc_pkg::OFS_BYTE_CTRL)   ? byte_ctrl_reg :
    (reg_addr == dtc_pkg::OFS_SHARED_CTRL) ? shared_reg    :
    (reg_addr == dtc_pkg::OFS_WORD_CTRL)   ? word_ctrl_reg :
    (reg_addr == dtc_pkg::OFS_BYTE_LOW)    ? byte_low_reg  :
    (reg_addr == dtc_pkg::OFS_BYTE_HIGH)   ? byte_high_reg :
    (reg_addr == dtc_pkg::OFS_WORD_LOW)    ? word_low_reg  :
    (reg_addr == dtc_pkg::OFS_WORD_HIGH)   ? word_high_reg : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // mode terms

  wire transmit = !shared_reg.demod;
  // alternating only while submode says so
  wire alt_mode = transmit && (shared_reg.submode == dtc_pkg::SUB_ALT);
  // forced levels on the word output
  wire word_forced = transmit && shared_reg.submode[1];
  wire word_force_level = (shared_reg.submode == dtc_pkg::SUB_HIGH);

  // a rising enable restarts from the hold values
  wire byte_start = byte_ctrl_reg.enable && !byte_en_prev_reg;
  wire word_start = word_ctrl_reg.enable && !word_en_prev_reg;
  // decrement only on a tick while enabled
  wire byte_step = tick_reg && byte_ctrl_reg.enable && !byte_start;
  wire word_step = tick_reg && word_ctrl_reg.enable && !word_start;
  // zero is reached from one; a zero count wraps through ff (ffff for the word timer) first
  wire byte_term = byte_step && (byte_cnt_reg == dtc_pkg::BYTE_LAST);
  wire word_term = word_step && (word_cnt_reg == dtc_pkg::WORD_LAST);

  // repeating mode flags only the half that closes a full cycle
  wire byte_tout = byte_term &&
    (byte_ctrl_reg.one_shot || (byte_out_reg != shared_reg.init_byte));
  wire word_tout = word_term &&
    (word_ctrl_reg.one_shot || (word_out_reg != shared_reg.init_word));

  // one-shot terminal hands over to the other timer
  wire byte_handoff = alt_mode && byte_term && byte_ctrl_reg.one_shot;
  wire word_handoff = alt_mode && word_term && word_ctrl_reg.one_shot;

  wire [15:0] word_hold = {word_high_reg, word_low_reg};

  ////////////////////////////////////////////////////////////////////////////
  // edge detector with glitch filter

  // input must hold a new level this long before it is accepted
  wire [4:0] glitch_len =
    (shared_reg.submode == 2'h0) ? dtc_pkg::GLITCH_W0 :
    (shared_reg.submode == 2'h1) ? dtc_pkg::GLITCH_W1 :
    (shared_reg.submode == 2'h2) ? dtc_pkg::GLITCH_W2 : dtc_pkg::GLITCH_W3;
  wire filt_differs = (demod_in != filt_reg);
  wire filt_accept  = filt_differs &&
    ((filt_cnt_reg + 5'h01) >= glitch_len);

  // logic select bit 0 enables rising, bit 1 falling
  wire rise_ev = shared_reg.demod && shared_reg.logic_sel[0] &&
    filt_reg && !filt_prev_reg;
  wire fall_ev = shared_reg.demod && shared_reg.logic_sel[1] &&
    !filt_reg && filt_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // output combiner

  wire comb_and = byte_out_reg & word_out_reg;
  wire comb_or  = byte_out_reg | word_out_reg;
  wire comb_val =
    (shared_reg.logic_sel == dtc_pkg::COMB_AND) ? comb_and  :
    (shared_reg.logic_sel == dtc_pkg::COMB_OR)  ? comb_or   :
    (shared_reg.logic_sel == dtc_pkg::COMB_NOR) ? !comb_or  : !comb_and;

  ////////////////////////////////////////////////////////////////////////////
  // control next values

  always_comb begin
    byte_ctrl_next = byte_ctrl_reg;
    if (wr_byte_ctrl) begin
      byte_ctrl_next = reg_wdata;
      byte_ctrl_next.timeout = byte_ctrl_reg.timeout &&
        !reg_wdata[dtc_pkg::TIMEOUT_BIT];
    end
    // one-shot stops itself at terminal count
    if (byte_term && byte_ctrl_reg.one_shot) begin
      byte_ctrl_next.enable = 1'b0;
    end
    // word timer finishing hands the run back
    if (word_handoff) begin
      byte_ctrl_next.enable = 1'b1;
    end
    // timeout set wins over a clearing write
    if (byte_tout) begin
      byte_ctrl_next.timeout = 1'b1;
    end
  end

  always_comb begin
    word_ctrl_next = word_ctrl_reg;
    if (wr_word_ctrl) begin
      word_ctrl_next = reg_wdata;
      word_ctrl_next.timeout = word_ctrl_reg.timeout &&
        !reg_wdata[dtc_pkg::TIMEOUT_BIT];
    end
    if (word_term && word_ctrl_reg.one_shot) begin
      word_ctrl_next.enable = 1'b0;
    end
    // byte timer finishing starts the word timer
    if (byte_handoff) begin
      word_ctrl_next.enable = 1'b1;
    end
    if (word_tout) begin
      word_ctrl_next.timeout = 1'b1;
    end
  end

  always_comb begin
    shared_next = shared_reg;
    if (wr_shared) begin
      shared_next = reg_wdata;
      if (shared_reg.demod) begin
        // rising flag cleared by writing 1
        shared_next.init_byte = shared_reg.init_byte &&
          !reg_wdata[dtc_pkg::RISE_BIT];
        // falling flag cleared by writing 1
        shared_next.init_word = shared_reg.init_word &&
          !reg_wdata[dtc_pkg::FALL_BIT];
      end
    end
    // detected rising edge sets its flag, beating a clear
    if (rise_ev) begin
      shared_next.init_byte = 1'b1;
    end
    // detected falling edge sets its flag
    if (fall_ev) begin
      shared_next.init_word = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counters and outputs next values

  always_comb begin
    byte_cnt_next = byte_cnt_reg;
    if (byte_start) begin
      // load side chosen by initial level
      byte_cnt_next = shared_reg.init_byte ? byte_high_reg : byte_low_reg;
    end else if (byte_term) begin
      // reload by the level the output toggles to
      // hold values only enter here and at start
      byte_cnt_next = byte_out_reg ? byte_low_reg : byte_high_reg;
    end else if (byte_step) begin
      byte_cnt_next = byte_cnt_reg - 8'h01;
    end
  end

  always_comb begin
    if (!byte_ctrl_reg.enable) begin
      // idle level is the inverse of the initial level
      byte_out_next = !shared_reg.init_byte;
    end else if (byte_start) begin
      byte_out_next = shared_reg.init_byte;
    end else if (byte_term) begin
      byte_out_next = !byte_out_reg;
    end else begin
      byte_out_next = byte_out_reg;
    end
  end

  always_comb begin
    word_cnt_next = word_cnt_reg;
    if (word_start || word_term) begin
      word_cnt_next = word_hold;
    end else if (word_step) begin
      word_cnt_next = word_cnt_reg - 16'h0001;
    end
  end

  always_comb begin
    if (word_forced) begin
      // initial level ignored in forced settings
      word_out_next = word_force_level;
    end else if (!word_ctrl_reg.enable) begin
      // idle at inverse of initial level
      word_out_next = !shared_reg.init_word;
    end else if (word_start) begin
      word_out_next = shared_reg.init_word;
    end else if (word_term) begin
      word_out_next = !word_out_reg;
    end else begin
      word_out_next = word_out_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file and timer state

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      byte_ctrl_reg <= dtc_pkg::TCTL_RESET;
      word_ctrl_reg <= dtc_pkg::TCTL_RESET;
      shared_reg    <= dtc_pkg::SCTL_RESET;
    end else begin
      byte_ctrl_reg <= byte_ctrl_next;
      word_ctrl_reg <= word_ctrl_next;
      shared_reg    <= shared_next;
    end
  end

  // hold registers accept writes at any time
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      byte_low_reg  <= 8'h00;
      byte_high_reg <= 8'h00;
      word_low_reg  <= 8'h00;
      word_high_reg <= 8'h00;
    end else begin
      if (wr_byte_low)  byte_low_reg  <= reg_wdata;
      if (wr_byte_high) byte_high_reg <= reg_wdata;
      if (wr_word_low)  word_low_reg  <= reg_wdata;
      if (wr_word_high) word_high_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      byte_cnt_reg     <= 8'h00;
      word_cnt_reg     <= 16'h0000;
      byte_out_reg     <= 1'b1;
      word_out_reg     <= 1'b1;
      byte_en_prev_reg <= 1'b0;
      word_en_prev_reg <= 1'b0;
    end else begin
      byte_cnt_reg     <= byte_cnt_next;
      word_cnt_reg     <= word_cnt_next;
      byte_out_reg     <= byte_out_next;
      word_out_reg     <= word_out_next;
      byte_en_prev_reg <= byte_ctrl_reg.enable;
      word_en_prev_reg <= word_ctrl_reg.enable;
    end
  end

  // timer clock: prescaler left out, a fixed divider stands in
  always_ff @(posedge clock) begin
    if (sys_rst || (tick_cnt_reg == dtc_pkg::TICK_DIV - 4'h1)) begin
      tick_cnt_reg <= 4'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == dtc_pkg::TICK_DIV - 4'h1);
    end
  end

  // glitch filter, counts stable cycles of a changed input
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      filt_reg      <= 1'b0;
      filt_prev_reg <= 1'b0;
      filt_cnt_reg  <= 5'h00;
    end else begin
      filt_prev_reg <= filt_reg;
      if (filt_accept) begin
        filt_reg     <= demod_in;
        filt_cnt_reg <= 5'h00;
      end else if (filt_differs) begin
        filt_cnt_reg <= filt_cnt_reg + 5'h01;
      end else begin
        filt_cnt_reg <= 5'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      first_pin_out  <= 1'b0;
      first_pin_oe   <= 1'b0;
      second_pin_out <= 1'b0;
      second_pin_oe  <= 1'b0;
      third_pin_out  <= 1'b0;
      third_pin_oe   <= 1'b0;
    end else begin
      first_pin_out  <= byte_ctrl_reg.pin_en & byte_out_reg;
      first_pin_oe   <= byte_ctrl_reg.pin_en;
      second_pin_out <= word_ctrl_reg.pin_en & word_out_reg;
      second_pin_oe  <= word_ctrl_reg.pin_en;
      // combined output on the third pin
      third_pin_out  <= shared_reg.comb_pin & comb_val;
      third_pin_oe   <= shared_reg.comb_pin;
    end
  end

  // interrupt request follows timeout when enabled
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      byte_irq <= 1'b0;
      word_irq <= 1'b0;
    end else begin
      byte_irq <= byte_ctrl_reg.timeout & byte_ctrl_reg.irq_en;
      word_irq <= word_ctrl_reg.timeout & word_ctrl_reg.irq_en;
    end
  end

endmodule

`default_nettype wire

// file: sim/dtc_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dtc_properties (
  // clock and reset
  input wire logic       clock,
  input wire logic       sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins and requests
  input wire logic       demod_in,
  input wire logic       first_pin_out,
  input wire logic       first_pin_oe,
  input wire logic       second_pin_out,
  input wire logic       second_pin_oe,
  input wire logic       third_pin_out,
  input wire logic       third_pin_oe,
  input wire logic       byte_irq,
  input wire logic       word_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [7:0] bctl_reg;
  logic [7:0] wctl_reg;
  logic [7:0] sh_reg;
  logic [1:0] quiet_reg;
  logic       alt_reg;
  wire        ctl_wr   = reg_wr && reg_addr <= 8'h02;
  wire        set_alt  = reg_wr && reg_addr == 8'h01 && reg_wdata[3:2] == 2'h1;
  wire        settled  = quiet_reg == 2'h3 && !sh_reg[7];
  wire        both_and = first_pin_out & second_pin_out;
  wire        both_or  = first_pin_out | second_pin_out;
  wire        comb_exp = sh_reg[5] ? !(sh_reg[4] ? both_and : both_or)
                                   : (sh_reg[4] ? both_or : both_and);
  ////////////////////////////////////////////////////////////////////////////
  // once submode 01 has been written, hardware owns the enables: rest checks stop
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bctl_reg  <= 8'h00;
      wctl_reg  <= 8'h00;
      sh_reg    <= 8'h00;
      quiet_reg <= 2'h0;
      alt_reg   <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h00) bctl_reg <= reg_wdata;
      if (reg_wr && reg_addr == 8'h02) wctl_reg <= reg_wdata;
      if (reg_wr && reg_addr == 8'h01) sh_reg <= reg_wdata;
      if (set_alt) alt_reg <= 1'b1;
      if (ctl_wr) quiet_reg <= 2'h0;
      else if (quiet_reg != 2'h3) quiet_reg <= quiet_reg + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  reset_quiet_a: assert property ($fell(sys_rst) |-> !first_pin_oe &&
    !second_pin_oe && !third_pin_oe && !byte_irq && !word_irq)
    else $error("outputs active right after reset");
  byte_irq_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h00
    |-> byte_irq == (reg_rdata[5] & reg_rdata[1]))
    else $error("byte request differs from its flags");
  word_irq_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 8'h02
    |-> word_irq == (reg_rdata[5] & reg_rdata[1]))
    else $error("word request differs from its flags");
  pin_gate_a: assert property (!first_pin_oe |-> !first_pin_out)
    else $error("first pin driven while not enabled");
  combine_out_a: assert property (
    settled && sh_reg[6] && first_pin_oe && second_pin_oe
    |-> third_pin_oe && third_pin_out == comb_exp)
    else $error("third pin is not the selected combination");
  forced_low_a: assert property (
    settled && sh_reg[3:2] == 2'h2 && second_pin_oe |-> !second_pin_out)
    else $error("word output not held low");
  byte_rest_a: assert property (
    settled && !alt_reg && !bctl_reg[7] && first_pin_oe
    |-> first_pin_out == !sh_reg[1])
    else $error("idle byte output not inverse of level");
  word_rest_a: assert property (
    settled && !alt_reg && sh_reg[3:2] == 2'h0 && !wctl_reg[7] &&
    second_pin_oe |-> second_pin_out == !sh_reg[0])
    else $error("idle word output not inverse of level");
  start_level_a: assert property (
    reg_wr && reg_addr == 8'h00 && reg_wdata[7] && reg_wdata[0] &&
    !bctl_reg[7] && !alt_reg && !sh_reg[7]
    |-> ##[2:4] first_pin_out == sh_reg[1])
    else $error("byte output did not start at its level");
endmodule
bind dtc_timer dtc_properties chk (.clock(clock), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .demod_in(demod_in),
  .first_pin_out(first_pin_out), .first_pin_oe(first_pin_oe),
  .second_pin_out(second_pin_out), .second_pin_oe(second_pin_oe),
  .third_pin_out(third_pin_out), .third_pin_oe(third_pin_oe),
  .byte_irq(byte_irq), .word_irq(word_irq));
`default_nettype wire

// file: sim/dtc_port_model.sv
`timescale 1ns/10ps
`default_nettype none
module dtc_port_model (
  // clock
  input  wire logic       clock,
  // pulse request
  input  wire logic       pulse_go,
  input  wire logic [4:0] pulse_len,
  // line into the block
  output logic            demod_in
);
  logic [4:0] left_reg;
  initial begin
    demod_in = 1'b0;
    left_reg = 5'h00;
  end
  // line idles low; a pulse shorter than the filter must read as a glitch
  always @(posedge clock) begin
    if (pulse_go) begin
      left_reg <= pulse_len;
      demod_in <= 1'b1;
    end else if (left_reg > 5'h01) begin
      left_reg <= left_reg - 5'h01;
    end else begin
      left_reg <= 5'h00;
      demod_in <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: sim/test_dual_timer_carrier_generator.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("[ERR] %0t got %0h exp %0h", $time, got, exp); \
  end \
end
module test_dual_timer_carrier_generator;
  logic       clock;
  logic       sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       demod_in;
  logic       pulse_go;
  logic [4:0] pulse_len;
  logic       first_pin_out, first_pin_oe, second_pin_out, second_pin_oe;
  logic       third_pin_out, third_pin_oe, byte_irq, word_irq;
  int         checks_done;
  int         n_mismatch;
  dtc_timer uut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .demod_in(demod_in),
    .first_pin_out(first_pin_out), .first_pin_oe(first_pin_oe),
    .second_pin_out(second_pin_out), .second_pin_oe(second_pin_oe),
    .third_pin_out(third_pin_out), .third_pin_oe(third_pin_oe),
    .byte_irq(byte_irq), .word_irq(word_irq));
  dtc_port_model model (.clock(clock), .pulse_go(pulse_go),
    .pulse_len(pulse_len), .demod_in(demod_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask
  // bounded: a pin that never moves ends the run
  task automatic wait_p(input logic sel, input logic lv, output int n);
    n = 0;
    #1;
    while ((sel ? second_pin_out : first_pin_out) !== lv) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 300) begin
        n_mismatch++;
        end_of_test();
      end
    end
  endtask
  task automatic pulse(input logic [4:0] len);
    @(posedge clock);
    pulse_go  <= 1'b1;
    pulse_len <= len;
    @(posedge clock);
    pulse_go  <= 1'b0;
    repeat (40) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int a = 0; a < 8; a++) rdc(a[7:0], 8'h00);
    wr(8'h03, 8'hff);
    rdc(8'h03, 8'h00);
    wr(8'h05, 8'ha5);
    rdc(8'h05, 8'ha5);
  endtask
  task automatic t_comb();
    logic b, w, e;
    wr(8'h00, 8'h01);
    wr(8'h02, 8'h01);
    for (int k = 0; k < 16; k++) begin
      b = !k[3];
      w = k[2];
      e = k[1] ? !(k[0] ? b & w : b | w) : (k[0] ? b | w : b & w);
      wr(8'h01, {2'b01, k[1:0], 1'b1, k[2], k[3], 1'b0});
      repeat (4) @(posedge clock);
      #1;
      `CHK({first_pin_oe, first_pin_out}, {1'b1, b})
      `CHK({second_pin_oe, second_pin_out}, {1'b1, w})
      `CHK({third_pin_oe, third_pin_out}, {1'b1, e})
    end
    for (int j = 0; j < 2; j++) begin
      wr(8'h01, {7'h00, j[0]});
      repeat (4) @(posedge clock);
      #1;
      `CHK({third_pin_oe, second_pin_out}, {1'b0, !j[0]})
    end
  endtask
  task automatic t_oneshot();
    int n;
    int cnt;
    wr(8'h04, 8'h03);
    wr(8'h05, 8'h06);
    for (int i = 0; i < 2; i++) begin
      cnt = i ? 6 : 3;
      wr(8'h00, 8'h01);
      wr(8'h01, {6'h00, i[0], 1'b0});
      wr(8'h00, 8'hc3);
      wait_p(1'b0, i[0], n);
      wait_p(1'b0, !i[0], n);
      `CHK(n >= 4 * cnt - 4 && n <= 4 * cnt + 1, 1'b1)
      rdc(8'h00, 8'h63);
      `CHK(byte_irq, 1'b1)
      wr(8'h00, 8'h63);
      rdc(8'h00, 8'h43);
    end
  endtask
  task automatic t_repeat();
    int n;
    wr(8'h01, 8'h00);
    wr(8'h04, 8'h02);
    wr(8'h05, 8'h03);
    wr(8'h00, 8'h81);
    wait_p(1'b0, 1'b0, n);
    wait_p(1'b0, 1'b1, n);
    wait_p(1'b0, 1'b0, n);
    `CHK(n, 12)
    wait_p(1'b0, 1'b1, n);
    `CHK(n, 8)
    wr(8'h05, 8'h05);
    wait_p(1'b0, 1'b0, n);
    `CHK(n, 10)
    wait_p(1'b0, 1'b1, n);
    wait_p(1'b0, 1'b0, n);
    `CHK(n, 20)
    rdc(8'h00, 8'ha1);
    wr(8'h00, 8'h21);
  endtask
  task automatic t_alt();
    int n;
    wr(8'h00, 8'h41);
    wr(8'h02, 8'h43);
    wr(8'h04, 8'h03);
    wr(8'h06, 8'h04);
    wr(8'h07, 8'h00);
    wr(8'h01, 8'h04);
    wr(8'h00, 8'hc1);
    wait_p(1'b0, 1'b0, n);
    wait_p(1'b0, 1'b1, n);
    wait_p(1'b1, 1'b0, n);
    rdc(8'h02, 8'hc3);
    rdc(8'h00, 8'h61);
    wr(8'h01, 8'h00);
    wait_p(1'b1, 1'b1, n);
    repeat (40) @(posedge clock);
    rdc(8'h00, 8'h61);
    rdc(8'h02, 8'h63);
    `CHK(word_irq, 1'b1)
  endtask
  task automatic t_demod();
    wr(8'h01, 8'hb4);
    pulse(5'h02);
    rdc(8'h01, 8'hb4);
    pulse(5'h0a);
    rdc(8'h01, 8'hb7);
    wr(8'h01, 8'hb7);
    rdc(8'h01, 8'hb4);
    wr(8'h01, 8'h94);
    pulse(5'h0a);
    rdc(8'h01, 8'h96);
    wr(8'h01, 8'hbe);
    pulse(5'h0a);
    rdc(8'h01, 8'hbc);
    pulse(5'h14);
    rdc(8'h01, 8'hbf);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    {sys_rst, reg_addr, reg_wdata, reg_wr, reg_rd} = 19'h40000;
    {pulse_go, pulse_len} = 6'h00;
    checks_done = 0;
    n_mismatch = 0;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs();
    t_comb();
    t_oneshot();
    t_repeat();
    t_alt();
    t_demod();
    end_of_test();
  end
endmodule
`default_nettype wire
